/* File: hw/sfb_bank.sv */
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - unimplemented addresses read zero; writes there are ignored
// - bank-independent registers decode identically in either bank
// - program counter upper byte is never mapped into register space
// - five-bit high latch supplies pc bits 12:8 on upper-byte transfer
// - power-on, brown-out, parity resets load power-on values; others differ
// - u bits keep contents, x bits load zero, q bits load ones
module sfb_bank (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic soft_reset_req,
	input wire sfb_pkg::sfb_cause_t soft_reset_cause,
	input wire logic pc_high_load,
	input wire logic [7:0] timer_in,
	input wire logic [7:0] result_in,
	input wire logic result_valid,
	output logic [4:0] pc_upper,
	output sfb_pkg::sfb_core_t core_regs,
	output logic [7:0] irq_control_out,
	output logic [7:0] converter_control_out,
	output logic [7:0] port_a_out,
	output logic [7:0] port_b_out
);
	// ==========================================
	// bus capture
	logic wr_pend;
	logic [7:0] wr_idx;
	logic [7:0] idx;
	logic rd_go;
	logic [7:0] eff_idx;
	logic bank;
	logic [7:0] rd_val;
	logic hit;

	logic [7:0] timer_count;
	logic [7:0] prog_counter_low;
	logic [7:0] core_status;
	logic [7:0] indirect_pointer;
	logic [7:0] port_a_data;
	logic [7:0] port_b_data;
	logic [7:0] prog_counter_high_latch;
	logic [7:0] irq_control;
	logic [7:0] periph_irq_flags;
	logic [7:0] conversion_result;
	logic [7:0] converter_control;
	logic [4:0] pc_high;
	sfb_pkg::sfb_cause_t last_cause;
	logic is_por;

	assign idx = haddr[9:2];
	assign bank = core_status[sfb_pkg::BANK_SEL_BIT];
	assign rd_go = hsel && hready && htrans[1] && !hwrite;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign is_por = (soft_reset_cause != sfb_pkg::SFB_CAUSE_OTHER);

	// bank 1 decodes only the shared registers here; rest reads zero
	always_comb begin
		eff_idx = idx;
		if (bank && idx[7]) begin
			eff_idx = {1'b0, idx[6:0]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
		end else begin
			wr_pend <= hsel && hready && htrans[1] && hwrite;
		end
	end

	// index held for the data phase; bank checked again at commit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_idx <= sfb_pkg::RST_ZERO;
		end else begin
			wr_idx <= eff_idx;
		end
	end

	// shared set: folding 0x80-range copies onto the same flops
	function automatic logic shared(input logic [7:0] a);
		shared = (a == sfb_pkg::IDX_INDIRECT_DATA_PORT) ||
			(a == sfb_pkg::IDX_PROG_COUNTER_LOW) ||
			(a == sfb_pkg::IDX_CORE_STATUS) ||
			(a == sfb_pkg::IDX_INDIRECT_POINTER) ||
			(a == sfb_pkg::IDX_PROG_COUNTER_HIGH_LATCH) ||
			(a == sfb_pkg::IDX_IRQ_CONTROL);
	endfunction

	// ==========================================
	// read mux
	always_comb begin
		rd_val = 8'h00;
		hit = !bank || shared(eff_idx);
		case (eff_idx)
			sfb_pkg::IDX_INDIRECT_DATA_PORT: rd_val = 8'h00;
			sfb_pkg::IDX_TIMER_COUNT: rd_val = timer_count;
			sfb_pkg::IDX_PROG_COUNTER_LOW: rd_val = prog_counter_low;
			sfb_pkg::IDX_CORE_STATUS: rd_val = core_status;
			sfb_pkg::IDX_INDIRECT_POINTER: rd_val = indirect_pointer;
			sfb_pkg::IDX_PORT_A_DATA: rd_val = port_a_data;
			sfb_pkg::IDX_PORT_B_DATA: rd_val = port_b_data;
			sfb_pkg::IDX_PROG_COUNTER_HIGH_LATCH:
				rd_val = prog_counter_high_latch;
			sfb_pkg::IDX_IRQ_CONTROL: rd_val = irq_control;
			sfb_pkg::IDX_PERIPH_IRQ_FLAGS: rd_val = periph_irq_flags;
			sfb_pkg::IDX_CONVERSION_RESULT: rd_val = conversion_result;
			sfb_pkg::IDX_CONVERTER_CONTROL: rd_val = converter_control;
			sfb_pkg::IDX_RESET_CAUSE: rd_val = {6'h00, last_cause};
			default: rd_val = 8'h00;
		endcase
		if (!hit) begin
			rd_val = 8'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= sfb_pkg::RST_RDATA;
		end else if (rd_go) begin
			hrdata <= {24'h00_0000, rd_val};
		end
	end

	// ==========================================
	// register file
	logic wr_ok;
	logic [7:0] wd;
	logic wr_timer;
	logic wr_pcl;
	logic wr_status;
	logic wr_pointer;
	logic wr_port_a;
	logic wr_port_b;
	logic wr_latch;
	logic wr_irq;
	logic wr_flags;
	logic wr_result;
	logic wr_conv;
	assign wd = hwdata[7:0];
	assign wr_ok = wr_pend && (!bank || shared(wr_idx));
	assign wr_timer = wr_ok && (wr_idx == sfb_pkg::IDX_TIMER_COUNT);
	assign wr_pcl = wr_ok && (wr_idx == sfb_pkg::IDX_PROG_COUNTER_LOW);
	assign wr_status = wr_ok && (wr_idx == sfb_pkg::IDX_CORE_STATUS);
	assign wr_pointer = wr_ok &&
		(wr_idx == sfb_pkg::IDX_INDIRECT_POINTER);
	assign wr_port_a = wr_ok && (wr_idx == sfb_pkg::IDX_PORT_A_DATA);
	assign wr_port_b = wr_ok && (wr_idx == sfb_pkg::IDX_PORT_B_DATA);
	assign wr_latch = wr_ok &&
		(wr_idx == sfb_pkg::IDX_PROG_COUNTER_HIGH_LATCH);
	assign wr_irq = wr_ok && (wr_idx == sfb_pkg::IDX_IRQ_CONTROL);
	assign wr_flags = wr_ok &&
		(wr_idx == sfb_pkg::IDX_PERIPH_IRQ_FLAGS);
	assign wr_result = wr_ok &&
		(wr_idx == sfb_pkg::IDX_CONVERSION_RESULT);
	assign wr_conv = wr_ok &&
		(wr_idx == sfb_pkg::IDX_CONVERTER_CONTROL);

	// soft resets: u bits kept, x taken as zero, q set to ones
	// timer follows its source; a bus write wins for one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_count <= sfb_pkg::RST_ZERO;
		end else if (soft_reset_req) begin
			if (is_por) begin
				timer_count <= sfb_pkg::RST_ZERO;
			end
		end else if (wr_timer) begin
			timer_count <= wd;
		end else begin
			timer_count <= timer_in;
		end
	end

	// both reset classes load zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prog_counter_low <= sfb_pkg::RST_ZERO;
		end else if (soft_reset_req) begin
			prog_counter_low <= sfb_pkg::RST_ZERO;
		end else if (wr_pcl) begin
			prog_counter_low <= wd;
		end
	end

	// other resets: bits 2:0 kept, 4:3 set to ones, 7:5 cleared
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_status <= sfb_pkg::RST_STATUS_POR;
		end else if (soft_reset_req) begin
			if (is_por) begin
				core_status <= sfb_pkg::RST_STATUS_POR;
			end else begin
				core_status <= (core_status & sfb_pkg::STATUS_KEEP_MASK) |
					(sfb_pkg::RST_STATUS_POR &
					sfb_pkg::STATUS_CAUSE_MASK);
			end
		end else if (wr_status) begin
			core_status <= wd;
		end
	end

	// pointer survives other resets
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			indirect_pointer <= sfb_pkg::RST_ZERO;
		end else if (soft_reset_req) begin
			if (is_por) begin
				indirect_pointer <= sfb_pkg::RST_ZERO;
			end
		end else if (wr_pointer) begin
			indirect_pointer <= wd;
		end
	end

	// only bit 4 survives other resets
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_a_data <= sfb_pkg::RST_ZERO;
		end else if (soft_reset_req) begin
			if (is_por) begin
				port_a_data <= sfb_pkg::RST_ZERO;
			end else begin
				port_a_data <= port_a_data &
					sfb_pkg::PORT_A_KEEP_MASK;
			end
		end else if (wr_port_a) begin
			port_a_data <= wd & sfb_pkg::PORT_A_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_b_data <= sfb_pkg::RST_ZERO;
		end else if (soft_reset_req) begin
			if (is_por) begin
				port_b_data <= sfb_pkg::RST_ZERO;
			end
		end else if (wr_port_b) begin
			port_b_data <= wd;
		end
	end

	// upper three bits never stored, so they read zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prog_counter_high_latch <= sfb_pkg::RST_ZERO;
		end else if (soft_reset_req) begin
			prog_counter_high_latch <= sfb_pkg::RST_ZERO;
		end else if (wr_latch) begin
			prog_counter_high_latch <= wd & sfb_pkg::LATCH_MASK;
		end
	end

	// flag bit 0 survives other resets
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_control <= sfb_pkg::RST_ZERO;
		end else if (soft_reset_req) begin
			if (is_por) begin
				irq_control <= sfb_pkg::RST_ZERO;
			end else begin
				irq_control <= irq_control &
					sfb_pkg::IRQ_KEEP_MASK;
			end
		end else if (wr_irq) begin
			irq_control <= wd;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			periph_irq_flags <= sfb_pkg::RST_ZERO;
		end else if (soft_reset_req) begin
			periph_irq_flags <= sfb_pkg::RST_ZERO;
		end else if (wr_flags) begin
			periph_irq_flags <= wd & sfb_pkg::PIR_MASK;
		end
	end

	// a bus write beats the converter strobe in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conversion_result <= sfb_pkg::RST_ZERO;
		end else if (soft_reset_req) begin
			if (is_por) begin
				conversion_result <= sfb_pkg::RST_ZERO;
			end
		end else if (wr_result) begin
			conversion_result <= wd;
		end else if (result_valid) begin
			conversion_result <= result_in;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			converter_control <= sfb_pkg::RST_ZERO;
		end else if (soft_reset_req) begin
			converter_control <= sfb_pkg::RST_ZERO;
		end else if (wr_conv) begin
			converter_control <= wd & sfb_pkg::ADC_MASK;
		end
	end

	// cause of the last soft reset, read-only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_cause <= sfb_pkg::SFB_CAUSE_POR;
		end else if (soft_reset_req) begin
			last_cause <= soft_reset_cause;
		end
	end

	// upper pc byte lives only here, no bus path to it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_high <= sfb_pkg::RST_PC_HIGH;
		end else if (soft_reset_req) begin
			pc_high <= sfb_pkg::RST_PC_HIGH;
		end else if (pc_high_load) begin
			pc_high <= prog_counter_high_latch[4:0];
		end
	end

	// ==========================================
	// outputs
	assign pc_upper = pc_high;
	// reserved bank bits passed as written; software keeps them clear
	assign core_regs = {prog_counter_high_latch, core_status,
		indirect_pointer};
	assign irq_control_out = irq_control;
	assign converter_control_out = converter_control;
	assign port_a_out = port_a_data;
	assign port_b_out = port_b_data;
endmodule
`default_nettype wire

/* File: hw/sfb_pkg.sv */
package sfb_pkg;
	// ==========================================
	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_INDIRECT_DATA_PORT = 8'h00;
	localparam logic [7:0] IDX_TIMER_COUNT = 8'h01;
	localparam logic [7:0] IDX_PROG_COUNTER_LOW = 8'h02;
	localparam logic [7:0] IDX_CORE_STATUS = 8'h03;
	localparam logic [7:0] IDX_INDIRECT_POINTER = 8'h04;
	localparam logic [7:0] IDX_PORT_A_DATA = 8'h05;
	localparam logic [7:0] IDX_PORT_B_DATA = 8'h06;
	localparam logic [7:0] IDX_PROG_COUNTER_HIGH_LATCH = 8'h0a;
	localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0b;
	localparam logic [7:0] IDX_PERIPH_IRQ_FLAGS = 8'h0c;
	localparam logic [7:0] IDX_CONVERSION_RESULT = 8'h1e;
	localparam logic [7:0] IDX_CONVERTER_CONTROL = 8'h1f;
	localparam logic [7:0] IDX_RESET_CAUSE = 8'h20;
	localparam logic [7:0] IDX_PC_HIGH = 8'h21;

	// ==========================================
	// bit positions and masks
	localparam int BANK_SEL_BIT = 5;
	localparam int UPPER_BANK_SELECT_BIT = 6;
	localparam int INDIRECT_BANK_BIT = 7;
	localparam logic [7:0] LATCH_MASK = 8'h1f;
	localparam logic [7:0] PORT_A_MASK = 8'h1f;
	localparam logic [7:0] PORT_A_KEEP_MASK = 8'h10;
	localparam logic [7:0] PIR_MASK = 8'h40;
	localparam logic [7:0] ADC_MASK = 8'hfd;
	localparam logic [7:0] STATUS_KEEP_MASK = 8'h07;
	localparam logic [7:0] STATUS_CAUSE_MASK = 8'h18;
	localparam logic [7:0] IRQ_KEEP_MASK = 8'h01;

	// ==========================================
	// reset values (x bits taken as zero)
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_STATUS_POR = 8'h18;
	localparam logic [4:0] RST_PC_HIGH = 5'h00;
	localparam logic [31:0] RST_RDATA = 32'h0000_0000;

	// ==========================================
	// reset causes
	typedef enum logic [1:0] {
		SFB_CAUSE_POR = 2'h0,
		SFB_CAUSE_BROWN_OUT_RESET = 2'h1,
		SFB_CAUSE_PARITY_ERROR_RESET = 2'h2,
		SFB_CAUSE_OTHER = 2'h3
	} sfb_cause_t;

	typedef struct packed {
		logic [7:0] prog_counter_high_latch;
		logic [7:0] core_status;
		logic [7:0] indirect_pointer;
	} sfb_core_t;
endpackage

/* File: verif/sfb_bank_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ======
// bank checker
module sfb_bank_props (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic soft_reset_req,
	input wire sfb_pkg::sfb_cause_t soft_reset_cause,
	input wire logic pc_high_load,
	input wire logic [4:0] pc_upper,
	input wire sfb_pkg::sfb_core_t core_regs,
	input wire logic [7:0] irq_control_out
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire logic oth = soft_reset_req &&
		soft_reset_cause == sfb_pkg::SFB_CAUSE_OTHER;
	wire logic [7:0] st = core_regs.core_status;
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus stall or error");
	chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_unmapped_read: assert property (
		hsel && htrans[1] && !hwrite &&
		haddr[9:2] inside {[8'h07:8'h09], [8'h0d:8'h1d], [8'h22:8'h7f]}
		|=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	chk_pc_transfer: assert property (
		pc_high_load && !soft_reset_req |=>
		pc_upper == $past(core_regs.prog_counter_high_latch[4:0]))
		else $error("upper pc not loaded");
	chk_latch_width: assert property (
		core_regs.prog_counter_high_latch[7:5] == 3'h0)
		else $error("latch wider than five bits");
	chk_pc_hidden: assert property (
		!pc_high_load && !soft_reset_req |=> $stable(pc_upper))
		else $error("upper pc changed");
	chk_soft_por: assert property (
		soft_reset_req && !oth |=>
		st == sfb_pkg::RST_STATUS_POR && irq_control_out == 8'h0)
		else $error("power-on values not loaded");
	chk_soft_other: assert property (
		oth |=> st == (8'h18 | ($past(st) & 8'h07)))
		else $error("status other reset wrong");
	chk_irq_keep: assert property (
		oth |=> irq_control_out == ($past(irq_control_out) & 8'h01))
		else $error("irq other reset wrong");
	cover property (pc_high_load);
	cover property (oth);
	cover property (st[5]);
endmodule
bind sfb_bank sfb_bank_props chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.soft_reset_req(soft_reset_req), .soft_reset_cause(soft_reset_cause),
	.pc_high_load(pc_high_load), .pc_upper(pc_upper),
	.core_regs(core_regs), .irq_control_out(irq_control_out));
`default_nettype wire

/* File: verif/tb_sfb_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_sfb_bank;
	logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0;
	logic [1:0] htrans = '0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic soft_reset_req = '0, pc_high_load = '0, result_valid = '0;
	logic hreadyout, hresp;
	sfb_pkg::sfb_cause_t soft_reset_cause = sfb_pkg::SFB_CAUSE_POR;
	logic [7:0] timer_in = '0, result_in = '0, rd, irq_o, adc_o, pa_o, pb_o;
	logic [7:0] mdl [256];
	logic [4:0] pc_upper;
	sfb_pkg::sfb_core_t core_regs;
	int mismatches = 0, num_checks = 0, seed = 32'h0311add7, i, c;
	always #5 hclk = ~hclk;
	sfb_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .soft_reset_req(soft_reset_req),
		.soft_reset_cause(soft_reset_cause), .pc_high_load(pc_high_load),
		.timer_in(timer_in), .result_in(result_in),
		.result_valid(result_valid), .pc_upper(pc_upper),
		.core_regs(core_regs), .irq_control_out(irq_o),
		.converter_control_out(adc_o), .port_a_out(pa_o), .port_b_out(pb_o));
	// ======
	// model: writable bits per index
	function automatic logic [7:0] msk(input int a);
		case (a)
			2, 4, 6, 11, 30: return 8'hff;
			5, 10: return 8'h1f;
			12: return 8'h40;
			31: return 8'hfd;
			default: return 8'h00;
		endcase
	endfunction
	// bank 1 shows only the shared set, in both halves; 255 is dead space
	function automatic int eff(input int a);
		logic s;
		s = (a % 128) inside {0, 2, 3, 4, 10, 11};
		if (a < 128 && (!mdl[3][5] || s)) return a;
		if (a >= 128 && mdl[3][5] && s) return a - 128;
		return 255;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ======
	// bus master
	task automatic bus(input logic w, input int a, input logic [31:0] d);
		int e;
		e = eff(a);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, a[7:0], 2'h0};
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		rd = hrdata[7:0];
		if (w) mdl[e] = (mdl[e] & ~msk(e)) | (d[7:0] & msk(e));
	endtask
	task automatic sweep(input int n);
		for (int k = 0; k < n; k++) begin
			bus(1'h0, k, 32'h0);
			chk(rd, mdl[eff(k)]);
		end
		chk(core_regs.indirect_pointer, mdl[4]);
		chk(core_regs.prog_counter_high_latch, mdl[10]);
		chk(irq_o, mdl[11]);
		chk(adc_o, mdl[31]);
		chk(pa_o, mdl[5]);
		chk(pb_o, mdl[6]);
	endtask
	task automatic fill();
		for (int k = 0; k < 64; k++) if (k != 3) bus(1'h1, k, $random(seed));
		timer_in <= $random(seed);
		result_in <= $random(seed);
		result_valid <= 1'h1;
		@(posedge hclk);
		result_valid <= 1'h0;
		mdl[30] = result_in;
		mdl[1] = timer_in;
	endtask
	task automatic sreset(input int c);
		@(posedge hclk);
		soft_reset_req <= 1'h1;
		soft_reset_cause <= sfb_pkg::sfb_cause_t'(c[1:0]);
		@(posedge hclk);
		soft_reset_req <= 1'h0;
		if (c < 3) begin
			foreach (mdl[k]) mdl[k] = 8'h0;
			mdl[3] = 8'h18;
		end else begin
			mdl[3] = 8'h18 | (mdl[3] & 8'h07);
			mdl[11] &= 8'h01;
			mdl[5] &= 8'h10;
			foreach (mdl[k]) if (k inside {2, 10, 12, 31}) mdl[k] = 8'h0;
		end
		mdl[1] = timer_in;
		mdl[32] = 8'(c);
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		summarize();
	end
	// ======
	// main sequence
	initial begin
		foreach (mdl[k]) mdl[k] = 8'h0;
		mdl[3] = 8'h18;
		timer_in = $random(seed);
		mdl[1] = timer_in;
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		sweep(64);
		fill();
		sweep(192);
		// bits 4:3 written as ones so either write policy reads back the same
		bus(1'h1, 3, 32'h38);
		mdl[3] = 8'h38;
		for (i = 128; i < 192; i++) if (i != 131) bus(1'h1, i, $random(seed));
		sweep(192);
		@(posedge hclk);
		pc_high_load <= 1'h1;
		@(posedge hclk);
		pc_high_load <= 1'h0;
		@(posedge hclk);
		chk({3'h0, pc_upper}, mdl[10]);
		for (c = 3; c < 7; c++) begin
			fill();
			sreset(c % 4);
			sweep(64);
		end
		summarize();
	end
endmodule
`default_nettype wire
